// File: verilog/slave_port_defs.svh
`ifndef SLAVE_PORT_DEFS_SVH
`define SLAVE_PORT_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_DATA_LATCH 8'h08
`define OFS_PIN_PORT 8'h09
`define OFS_IRQ_FLAGS 8'h0C
`define OFS_DATA_DIR 8'h88
`define OFS_CTRL_STATUS 8'h89
`define OFS_IRQ_ENABLES 8'h8C
`define OFS_ANALOG_CFG 8'h9F

// ****************************************
// Field positions
// ****************************************
`define CTRL_IN_FULL 7
`define CTRL_OUT_FULL 6
`define CTRL_OVERRUN 5
`define CTRL_MODE 4
`define IRQ_SLAVE_BIT 7
`define PIN_RD 0
`define PIN_WR 1
`define PIN_CS 2

// ****************************************
// Reset values
// ****************************************
`define RST_CTRL_STATUS 8'h07
`define RST_DATA_DIR 8'hFF
`define RST_IRQ_FLAGS 8'h00
`define RST_IRQ_ENABLES 8'h00
`define RST_ANALOG_CFG 4'h0
`define RST_LATCH 8'h00

// ****************************************
// Timing
// ****************************************
`define SYNC_STAGES 2

`endif

// File: verilog/slave_port_pkg.sv
package slave_port_pkg;

    // Port E strobes seen in slave mode, all active low
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } strobe_t;

    // Control and status register layout
    typedef struct packed {
        logic in_full_flag;
        logic out_full_flag;
        logic in_overrun_flag;
        logic slave_port_select;
        logic unused;
        logic [2:0] port_e_dir;
    } ctrl_t;

    // Four quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        PH_FIRST = 4'h1,
        PH_SECOND = 4'h2,
        PH_THIRD = 4'h4,
        PH_FOURTH = 4'h8
    } phase_t;

    // Completion sequencer after a strobe ends
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_WAIT_SECOND = 3'h2,
        SEQ_WAIT_FOURTH = 3'h4
    } seq_t;

endpackage : slave_port_pkg

// File: verilog/pin_sync.sv
`timescale 1ns/1ns
`include "slave_port_defs.svh"

module pin_sync #(
    parameter int WIDTH = 11
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Asynchronous levels in, synchronous levels out
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] rst_val,
    output logic [WIDTH-1:0] sync_o
);

    // ****************************************
    // Per-bit two-stage synchroniser
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [`SYNC_STAGES-1:0] stage_q;
            // First stage feeds only the second
            // Reset loads the idle level, so no false strobe follows reset
            always_ff @(posedge sys_clk) begin
                if (!rst_b) begin
                    stage_q <= {`SYNC_STAGES{rst_val[gi]}};
                end else if (clk_en) begin
                    stage_q <= {stage_q[0], async_i[gi]};
                end
            end
            // Only the second stage is visible to logic
            assign sync_o[gi] = stage_q[1];
        end
    endgenerate

endmodule : pin_sync

// File: verilog/slave_port_core.sv
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`include "slave_port_defs.svh"

module slave_port_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Data port pins
    input wire logic [7:0] data_pin_i,
    output logic [7:0] data_pin_o,
    output logic [7:0] data_pin_oe,
    // Port E pins: read, write, select strobes
    input wire logic [2:0] pe_pin_i,
    output logic [2:0] pe_pin_o,
    output logic [2:0] pe_pin_oe,
    // Interrupt request
    output logic irq_req
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    logic [10:0] pins_s;
    logic [7:0] data_s;
    slave_port_pkg::strobe_t strb_s;

    // Strobes and data share one sync so captured data lines up
    pin_sync #(
        .WIDTH(11)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .async_i({pe_pin_i, data_pin_i}),
        .rst_val(11'h700),
        .sync_o(pins_s)
    );

    assign data_s = pins_s[7:0];
    assign strb_s.cs_n = pins_s[8 + `PIN_CS];
    assign strb_s.wr_n = pins_s[8 + `PIN_WR];
    assign strb_s.rd_n = pins_s[8 + `PIN_RD];

    // ****************************************
    // Registers
    // ****************************************
    slave_port_pkg::ctrl_t ctrl_q;
    logic [7:0] out_latch_q;
    logic [7:0] in_latch_q;
    logic [7:0] dir_q;
    logic [2:0] pe_out_q;
    logic [7:0] irq_flags_q;
    logic [7:0] irq_en_q;
    logic [3:0] analog_cfg_q;
    logic [7:0] rdata_q;
    logic ovr_read_seen_q;
    logic wr_act_q;
    logic rd_act_q;
    slave_port_pkg::phase_t ph_q;
    slave_port_pkg::seq_t wseq_q;
    slave_port_pkg::seq_t rseq_q;

    // ****************************************
    // Decode and strobe activity
    // ****************************************
    logic mode;
    logic wr_act;
    logic rd_act;
    logic wr_end;
    logic rd_begin;
    logic rd_end;
    logic wr_done;
    logic rd_done;
    logic fw_data_rd;
    logic fw_data_wr;
    logic fw_ctrl_wr;
    logic fw_flags_wr;

    assign mode = ctrl_q.slave_port_select;
    // Strobe counts only while selected
    assign wr_act = mode & ~strb_s.cs_n & ~strb_s.wr_n;
    assign rd_act = mode & ~strb_s.cs_n & ~strb_s.rd_n;
    // Either line rising ends the access
    assign wr_end = wr_act_q & ~wr_act;
    assign rd_end = rd_act_q & ~rd_act;
    assign rd_begin = rd_act & ~rd_act_q;
    assign fw_data_rd = reg_rd & (reg_addr == `OFS_DATA_LATCH);
    assign fw_data_wr = reg_wr & (reg_addr == `OFS_DATA_LATCH);
    assign fw_ctrl_wr = reg_wr & (reg_addr == `OFS_CTRL_STATUS);
    assign fw_flags_wr = reg_wr & (reg_addr == `OFS_IRQ_FLAGS);
    assign wr_done = (wseq_q == slave_port_pkg::SEQ_WAIT_FOURTH) &&
                     (ph_q == slave_port_pkg::PH_FOURTH);
    assign rd_done = (rseq_q == slave_port_pkg::SEQ_WAIT_FOURTH) &&
                     (ph_q == slave_port_pkg::PH_FOURTH);

    // Strobe activity history for edge detection
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_act_q <= 1'b0;
            rd_act_q <= 1'b0;
        end else if (clk_en) begin
            wr_act_q <= wr_act;
            rd_act_q <= rd_act;
        end
    end

    // ****************************************
    // Quarter phase generator
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ph_q <= slave_port_pkg::PH_FIRST;
        end else if (clk_en) begin
            unique case (ph_q)
                slave_port_pkg::PH_FIRST: ph_q <= slave_port_pkg::PH_SECOND;
                slave_port_pkg::PH_SECOND: ph_q <= slave_port_pkg::PH_THIRD;
                slave_port_pkg::PH_THIRD: ph_q <= slave_port_pkg::PH_FOURTH;
                slave_port_pkg::PH_FOURTH: ph_q <= slave_port_pkg::PH_FIRST;
                default: ph_q <= slave_port_pkg::PH_FIRST;
            endcase
        end
    end

    // ****************************************
    // Completion sequencers
    // ****************************************
    // A second phase must pass before the fourth counts
    function automatic slave_port_pkg::seq_t seq_next(
        input slave_port_pkg::seq_t cur,
        input logic start,
        input slave_port_pkg::phase_t ph
    );
        slave_port_pkg::seq_t nxt;
        nxt = cur;
        unique case (cur)
            slave_port_pkg::SEQ_IDLE: begin
                if (start) begin
                    nxt = slave_port_pkg::SEQ_WAIT_SECOND;
                end
            end
            slave_port_pkg::SEQ_WAIT_SECOND: begin
                if (ph == slave_port_pkg::PH_SECOND) begin
                    nxt = slave_port_pkg::SEQ_WAIT_FOURTH;
                end
            end
            slave_port_pkg::SEQ_WAIT_FOURTH: begin
                if (ph == slave_port_pkg::PH_FOURTH) begin
                    nxt = slave_port_pkg::SEQ_IDLE;
                end
            end
            default: nxt = slave_port_pkg::SEQ_IDLE;
        endcase
        return nxt;
    endfunction : seq_next

    // Write and read completions run independently
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wseq_q <= slave_port_pkg::SEQ_IDLE;
            rseq_q <= slave_port_pkg::SEQ_IDLE;
        end else if (clk_en) begin
            wseq_q <= seq_next(wseq_q, wr_end, ph_q);
            rseq_q <= seq_next(rseq_q, rd_end, ph_q);
        end
    end

    // ****************************************
    // Data latches
    // ****************************************
    // Input latch overwritten even when still full
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            in_latch_q <= `RST_LATCH;
        end else if (clk_en && wr_end) begin
            in_latch_q <= data_s;
        end
    end

    // Output latch written by firmware only
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            out_latch_q <= `RST_LATCH;
        end else if (clk_en && fw_data_wr) begin
            out_latch_q <= reg_wdata;
        end
    end

    // Plain direction and port E latches
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            dir_q <= `RST_DATA_DIR;
            pe_out_q <= 3'h0;
            analog_cfg_q <= `RST_ANALOG_CFG;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `OFS_DATA_DIR) begin
                dir_q <= reg_wdata;
            end
            if (reg_addr == `OFS_PIN_PORT) begin
                pe_out_q <= reg_wdata[2:0];
            end
            if (reg_addr == `OFS_ANALOG_CFG) begin
                analog_cfg_q <= reg_wdata[3:0];
            end
        end
    end

    // ****************************************
    // Control and status register
    // ****************************************
    // Input-full and overrun: hardware set beats firmware clear; output-full: read clear beats firmware set
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_q <= `RST_CTRL_STATUS;
        end else if (clk_en) begin
            if (fw_ctrl_wr) begin
                ctrl_q.slave_port_select <= reg_wdata[`CTRL_MODE];
                ctrl_q.port_e_dir <= reg_wdata[2:0];
            end
            if (!mode) begin
                ctrl_q.in_full_flag <= 1'b0;
            end else if (wr_done) begin
                ctrl_q.in_full_flag <= 1'b1;
            end else if (fw_data_rd) begin
                ctrl_q.in_full_flag <= 1'b0;
            end
            if (!mode || rd_begin || rd_act) begin
                ctrl_q.out_full_flag <= 1'b0;
            end else if (fw_data_wr) begin
                ctrl_q.out_full_flag <= 1'b1;
            end
            if (wr_done && ctrl_q.in_full_flag) begin
                ctrl_q.in_overrun_flag <= 1'b1;
            end else if (fw_ctrl_wr && !reg_wdata[`CTRL_OVERRUN] &&
                         ovr_read_seen_q) begin
                ctrl_q.in_overrun_flag <= 1'b0;
            end
        end
    end

    // Remembers a data read since the overrun arose
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ovr_read_seen_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_done && ctrl_q.in_full_flag) begin
                ovr_read_seen_q <= 1'b0;
            end else if (fw_data_rd) begin
                ovr_read_seen_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interrupt flags and enables
    // ****************************************
    // Completion beats a same-cycle firmware clear
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_flags_q <= `RST_IRQ_FLAGS;
        end else if (clk_en) begin
            if (fw_flags_wr) begin
                irq_flags_q <= reg_wdata;
            end
            if (wr_done || rd_done) begin
                irq_flags_q[`IRQ_SLAVE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_en_q <= `RST_IRQ_ENABLES;
        end else if (clk_en && reg_wr &&
                     reg_addr == `OFS_IRQ_ENABLES) begin
            irq_en_q <= reg_wdata;
        end
    end

    // Registered request, masked by the enable bit
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
        end else if (clk_en) begin
            irq_req <= irq_flags_q[`IRQ_SLAVE_BIT] &
                       irq_en_q[`IRQ_SLAVE_BIT];
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Unmapped offsets read zero; data one cycle later
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (clk_en) begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    `OFS_DATA_LATCH: begin
                        if (!mode || wr_act) begin
                            rdata_q <= data_s;
                        end else begin
                            rdata_q <= in_latch_q;
                        end
                    end
                    `OFS_PIN_PORT: rdata_q <= {5'h00, pins_s[10:8]};
                    `OFS_IRQ_FLAGS: rdata_q <= irq_flags_q;
                    `OFS_DATA_DIR: rdata_q <= dir_q;
                    `OFS_CTRL_STATUS: rdata_q <= {ctrl_q[7:4], 1'b0,
                                                  ctrl_q[2:0]};
                    `OFS_IRQ_ENABLES: rdata_q <= irq_en_q;
                    `OFS_ANALOG_CFG: rdata_q <= {4'h0, analog_cfg_q};
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************
    // Pin drivers
    // ****************************************
    // Latch goes straight out, so a write during a read passes through
    assign data_pin_o = out_latch_q;
    // Slave mode: direction register ignored, master steers
    assign data_pin_oe = mode ? {8{rd_act}} : ~dir_q;
    assign pe_pin_o = pe_out_q;
    // Strobe pins never driven in slave mode, whatever software did
    assign pe_pin_oe = mode ? 3'h0 : ~ctrl_q.port_e_dir;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b || !clk_en);

    AST_MODE_SELECTS_DRIVE: assert property (
        mode && !rd_act |-> data_pin_oe == 8'h00
    ) else $error("slave mode drives pins without a read");

    AST_WRITE_END_SETS_FULL: assert property (
        mode && wr_end |-> ##[3:8] ctrl_q.in_full_flag || !mode
    ) else $error("input-full not set after external write");

    AST_WRITE_END_CAPTURE: assert property (
        wr_end |=> in_latch_q == $past(data_s)
    ) else $error("input latch missed strobe-end data");

    AST_READ_START_CLEARS: assert property (
        rd_begin |=> !ctrl_q.out_full_flag
    ) else $error("output-full not cleared at read start");

    AST_READ_DRIVES: assert property (
        rd_act && rd_act_q |-> data_pin_oe == 8'hFF && !ctrl_q.out_full_flag
    ) else $error("output latch not driven during read");

    AST_READ_END_FLAG: assert property (
        rd_end |-> ##[3:8] irq_flags_q[`IRQ_SLAVE_BIT]
    ) else $error("flag not raised after read end");

    AST_MODE_OFF_CLEAR: assert property (
        !mode |=> !ctrl_q.in_full_flag && !ctrl_q.out_full_flag
    ) else $error("full flags not held clear outside mode");

    AST_OVERRUN_STICKY: assert property (
        ctrl_q.in_overrun_flag && !fw_ctrl_wr |=> ctrl_q.in_overrun_flag
    ) else $error("overrun cleared without firmware write");

    AST_FW_WRITE_SETS_FULL: assert property (
        mode && fw_data_wr && !rd_act && !rd_begin
        |=> ctrl_q.out_full_flag
    ) else $error("firmware write did not set output-full");

    AST_IRQ_MASK: assert property (
        !irq_en_q[`IRQ_SLAVE_BIT] |=> !irq_req
    ) else $error("request raised while masked");

endmodule : slave_port_core

// File: sim/ext_master.sv
`timescale 1ns/1ns

// ****************************************
// External bus master model
// ****************************************
module ext_master (
    // Clock used only to pace the model
    input wire logic sys_clk,
    // Strobes toward the port, all active low
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    // Data bus drive and observed bus level
    output logic [7:0] drv_d,
    output logic drv_en,
    input wire logic [7:0] bus_d
);
    // Idle bus: not selected, no strobe, data released
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        drv_d = 8'h00;
        drv_en = 1'b0;
    end

    // Strobes move 1 ns after an edge of the same clock the port runs on
    task automatic begin_write(input logic [7:0] d, input logic sel);
        @(posedge sys_clk);
        #1;
        drv_d = d;
        drv_en = 1'b1;
        cs_n = ~sel;
        wr_n = 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : begin_write

    // Data held a few cycles past the strobe end, then released
    task automatic end_write();
        @(posedge sys_clk);
        #1;
        wr_n = 1'b1;
        cs_n = 1'b1;
        fork
            begin
                repeat (3) @(posedge sys_clk);
                #1;
                drv_en = 1'b0;
            end
        join_none
    endtask : end_write

    task automatic begin_read(input logic sel);
        @(posedge sys_clk);
        #1;
        cs_n = ~sel;
        rd_n = 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : begin_read

    // Bus value taken just before the read strobe rises
    task automatic end_read(output logic [7:0] got);
        @(posedge sys_clk);
        #1;
        got = bus_d;
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask : end_read
endmodule : ext_master

// File: sim/tb_top.sv
`timescale 1ns/1ns
`include "slave_port_defs.svh"

module tb_top;
    logic sys_clk;
    logic rst_b;
    logic clk_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] data_pin_o;
    logic [7:0] data_pin_oe;
    logic [2:0] pe_pin_o;
    logic [2:0] pe_pin_oe;
    logic irq_req;
    logic [7:0] data_bus;
    logic [2:0] pe_bus;
    logic [7:0] idle_pat;
    logic m_cs_n;
    logic m_wr_n;
    logic m_rd_n;
    logic [7:0] m_drv_d;
    logic m_drv_en;
    logic [7:0] got;
    int miscompares;
    int checks_done;
    logic [7:0] ra [6] = '{8'h89, 8'h0C, 8'h8C, 8'h88, 8'h9F, 8'h55};
    logic [7:0] rv [6] = '{8'h07, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};

    // ****************************************
    // Clock, pins and instances
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Released bus lines wander so stale values cannot pass
    initial idle_pat = 8'h5A;
    always @(posedge sys_clk) idle_pat <= idle_pat + 8'h35;

    // Wire levels resolved from every driver's enable
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            data_bus[i] = data_pin_oe[i] ? data_pin_o[i] :
                          (m_drv_en ? m_drv_d[i] : idle_pat[i]);
        end
        pe_bus[0] = pe_pin_oe[0] ? pe_pin_o[0] : m_rd_n;
        pe_bus[1] = pe_pin_oe[1] ? pe_pin_o[1] : m_wr_n;
        pe_bus[2] = pe_pin_oe[2] ? pe_pin_o[2] : m_cs_n;
    end

    slave_port_core dut_u (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .data_pin_i(data_bus), .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe), .pe_pin_i(pe_bus),
        .pe_pin_o(pe_pin_o), .pe_pin_oe(pe_pin_oe), .irq_req(irq_req)
    );

    ext_master ext_u (
        .sys_clk(sys_clk), .cs_n(m_cs_n), .wr_n(m_wr_n), .rd_n(m_rd_n),
        .drv_d(m_drv_d), .drv_en(m_drv_en), .bus_d(data_bus)
    );

    // ****************************************
    // Access and compare tasks
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // A spare edge before each strobe keeps drivers single per step
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rd_chk

    // Request must rise within the phase window, not before it
    task automatic wait_irq();
        int n;
        logic ok;
        n = 0;
        while (irq_req !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        ok = (n >= 3 && n <= 14);
        check("irq_req delay", {7'h00, ok}, 8'h01);
    endtask : wait_irq

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Run is a few hundred cycles; this limit is generous
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        // Reset values, unmapped offset last
        for (int i = 0; i < 6; i++) begin
            rd_chk(ra[i], rv[i]);
        end
        check("irq_req", {7'h00, irq_req}, 8'h00);
        check("data_pin_oe", data_pin_oe, 8'h00);
        // Digital pins, port E inputs, slave mode, direction ignored
        reg_write(`OFS_ANALOG_CFG, 8'h0F);
        rd_chk(`OFS_ANALOG_CFG, 8'h0F);
        reg_write(`OFS_CTRL_STATUS, 8'h17);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        reg_write(`OFS_DATA_DIR, 8'h00);
        repeat (2) @(posedge sys_clk);
        check("data_pin_oe", data_pin_oe, 8'h00);
        reg_write(`OFS_IRQ_ENABLES, 8'h80);
        // External write: live pins, then latch and flags
        ext_u.begin_write(8'h3C, 1'b1);
        rd_chk(`OFS_DATA_LATCH, 8'h3C);
        ext_u.end_write();
        wait_irq();
        rd_chk(`OFS_CTRL_STATUS, 8'h97);
        rd_chk(`OFS_IRQ_FLAGS, 8'h80);
        rd_chk(`OFS_DATA_LATCH, 8'h3C);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        rd_chk(`OFS_IRQ_FLAGS, 8'h80);
        // Mask, unmask, firmware clear
        reg_write(`OFS_IRQ_ENABLES, 8'h00);
        repeat (2) @(posedge sys_clk);
        check("irq_req masked", {7'h00, irq_req}, 8'h00);
        reg_write(`OFS_IRQ_ENABLES, 8'h80);
        repeat (2) @(posedge sys_clk);
        check("irq_req", {7'h00, irq_req}, 8'h01);
        // Frozen clock enable must drop a register write
        @(posedge sys_clk);
        clk_en <= 1'b0;
        reg_write(`OFS_IRQ_ENABLES, 8'h00);
        clk_en <= 1'b1;
        rd_chk(`OFS_IRQ_ENABLES, 8'h80);
        reg_write(`OFS_IRQ_FLAGS, 8'h00);
        repeat (2) @(posedge sys_clk);
        check("irq_req cleared", {7'h00, irq_req}, 8'h00);
        // Two writes unread: overrun, overwrite, clear conditions
        ext_u.begin_write(8'h11, 1'b1);
        ext_u.end_write();
        wait_irq();
        reg_write(`OFS_IRQ_FLAGS, 8'h00);
        ext_u.begin_write(8'h22, 1'b1);
        ext_u.end_write();
        wait_irq();
        rd_chk(`OFS_CTRL_STATUS, 8'hB7);
        reg_write(`OFS_CTRL_STATUS, 8'h17);
        rd_chk(`OFS_CTRL_STATUS, 8'hB7);
        rd_chk(`OFS_DATA_LATCH, 8'h22);
        rd_chk(`OFS_CTRL_STATUS, 8'h37);
        reg_write(`OFS_DATA_LATCH, 8'h99);
        rd_chk(`OFS_CTRL_STATUS, 8'h77);
        reg_write(`OFS_CTRL_STATUS, 8'h27);
        rd_chk(`OFS_CTRL_STATUS, 8'h27);
        // Outside slave mode the direction bits steer every pin
        reg_write(`OFS_PIN_PORT, 8'h05);
        reg_write(`OFS_CTRL_STATUS, 8'h20);
        repeat (2) @(posedge sys_clk);
        check("pe_pin_oe", {5'h00, pe_pin_oe}, 8'h07);
        check("pe_pin_o", {5'h00, pe_pin_o}, 8'h05);
        check("data_pin_oe", data_pin_oe, 8'hFF);
        rd_chk(`OFS_PIN_PORT, 8'h05);
        reg_write(`OFS_CTRL_STATUS, 8'h17);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        // Slave mode keeps strobe pins undriven, whatever the direction
        reg_write(`OFS_CTRL_STATUS, 8'h10);
        rd_chk(`OFS_CTRL_STATUS, 8'h10);
        check("pe_pin_oe", {5'h00, pe_pin_oe}, 8'h00);
        reg_write(`OFS_CTRL_STATUS, 8'h17);
        reg_write(`OFS_IRQ_FLAGS, 8'h00);
        // External read with a firmware write in the middle
        reg_write(`OFS_DATA_LATCH, 8'h5A);
        rd_chk(`OFS_CTRL_STATUS, 8'h57);
        ext_u.begin_read(1'b1);
        check("data_pin_oe", data_pin_oe, 8'hFF);
        check("data bus", data_bus, 8'h5A);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        reg_write(`OFS_DATA_LATCH, 8'hC3);
        @(posedge sys_clk);
        #1;
        check("data bus", data_bus, 8'hC3);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        ext_u.end_read(got);
        wait_irq();
        check("master read", got, 8'hC3);
        check("data_pin_oe", data_pin_oe, 8'h00);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        reg_write(`OFS_IRQ_FLAGS, 8'h00);
        // Strobes while not selected are ignored
        ext_u.begin_write(8'hE7, 1'b0);
        ext_u.end_write();
        ext_u.begin_read(1'b0);
        check("data_pin_oe", data_pin_oe, 8'h00);
        ext_u.end_read(got);
        repeat (16) @(posedge sys_clk);
        #1;
        check("irq_req", {7'h00, irq_req}, 8'h00);
        rd_chk(`OFS_CTRL_STATUS, 8'h17);
        rd_chk(`OFS_DATA_LATCH, 8'h22);
        tally_and_finish();
    end
endmodule : tb_top
